// >>> hdl/essi_defines.vh
// Constants for the external start/stop interlock block
`ifndef ESSI_DEFINES_VH
`define ESSI_DEFINES_VH

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define ESSI_CLK_HZ          50000000
`define ESSI_MIN_CLOSE_US    1000
// 1 ms at 50 MHz, sized to fit the filter counter
`define ESSI_MIN_CLOSE_CYC   16'hC350
`define ESSI_CNT_W           16
// Short glitch filter for the momentary stop closure and the safety loop
`define ESSI_MOMENT_CYC      16'h0004

// -----------------------------------------------------------------
// Control source selection
// -----------------------------------------------------------------
`define ESSI_SRC_W           2
`define ESSI_SRC_PANEL       2'h0
`define ESSI_SRC_HANDHELD    2'h1
`define ESSI_SRC_SIGIO       2'h2

// -----------------------------------------------------------------
// Test states
// -----------------------------------------------------------------
`define ESSI_ST_W            2
`define ESSI_ST_IDLE         2'h0
`define ESSI_ST_READY        2'h1
`define ESSI_ST_RUN          2'h2

// -----------------------------------------------------------------
// Status output bit positions
// -----------------------------------------------------------------
`define ESSI_STAT_W          5
`define ESSI_STAT_READY      0
`define ESSI_STAT_RUN        1
`define ESSI_STAT_PASS       2
`define ESSI_STAT_FAIL       3
`define ESSI_STAT_LOCKOK     4

`endif

// >>> hdl/essi_sync.v
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/1ps
`default_nettype none

module essi_sync (
    // Clock and reset
    input  wire core_clk,
    input  wire reset_n,
    // Data
    input  wire asyncIn,
    output reg  syncOut
);

    reg stage1;

    // -----------------------------------------------------------------
    // Sync chain
    // -----------------------------------------------------------------
    // First stage feeds only the second
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule

`default_nettype wire

// >>> hdl/essi_filter.v
// Stability filter: level must hold for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
`include "essi_defines.vh"

module essi_filter #(
    parameter [`ESSI_CNT_W-1:0] HOLD_CYC = 16'h0001
) (
    // Clock and reset
    input  wire core_clk,
    input  wire reset_n,
    // Synchronised raw level, high when closed
    input  wire rawIn,
    // Filtered level and its rising pulse
    output reg  stableOut,
    output reg  risePulse
);

    reg [`ESSI_CNT_W-1:0] holdCount;

    // -----------------------------------------------------------------
    // Filter
    // -----------------------------------------------------------------
    // Any return to the stable level restarts the count, so bounce never leaks through
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            holdCount <= {`ESSI_CNT_W{1'b0}};
            stableOut <= 1'b0;
            risePulse <= 1'b0;
        end else begin
            risePulse <= 1'b0;
            if (rawIn == stableOut) begin
                holdCount <= {`ESSI_CNT_W{1'b0}};
            end else if (holdCount >= HOLD_CYC - 16'h0001) begin
                holdCount <= {`ESSI_CNT_W{1'b0}};
                stableOut <= rawIn;
                risePulse <= rawIn;
            end else begin
                holdCount <= holdCount + 16'h0001;
            end
        end
    end

endmodule

`default_nettype wire

// >>> hdl/essi_top.v
// External start/stop source selection and interlock gating
`timescale 1ns/1ps
`default_nettype none
`include "essi_defines.vh"

module essi_top (
    // Clock and reset
    input  wire                   core_clk,
    input  wire                   reset_n,
    // Settings from the instrument
    input  wire [`ESSI_SRC_W-1:0] controlSource,
    input  wire                   interlockEnable,
    // Front panel buttons, active high, same clock domain
    input  wire                   panelStart,
    input  wire                   panelStop,
    // Handheld terminal contacts, low when closed to common
    input  wire                   handheld_start_in_n,
    input  wire                   handheld_stop_in_n,
    // Signal port contacts, low when closed to common
    input  wire                   portStart_n,
    input  wire                   portStop_n,
    // Safety loop: driven low on loop A, seen low on loop B when shorted
    input  wire                   safety_loop_b,
    output reg                    safety_loop_a,
    // Test engine handshake
    input  wire                   testDone,
    input  wire                   testPass,
    output reg                    testStart,
    output reg                    testAbort,
    // Status lines on the signal port
    output reg  [`ESSI_STAT_W-1:0] statusOut
);

    localparam [`ESSI_CNT_W-1:0] MIN_CYC = `ESSI_MIN_CLOSE_CYC;
    localparam [`ESSI_CNT_W-1:0] MOM_CYC = `ESSI_MOMENT_CYC;

    // -----------------------------------------------------------------
    // Source decode
    // -----------------------------------------------------------------
    function isSrc;
        input [`ESSI_SRC_W-1:0] sel;
        input [`ESSI_SRC_W-1:0] want;
        begin
            isSrc = (sel == want);
        end
    endfunction

    wire [4:0] rawPins;
    wire [4:0] syncPins;
    wire       hhStartOk;
    wire       hhStopOk;
    wire       ptStartOk;
    wire       ptStopHold;
    wire       ptStopMom;
    wire       loopClosed;
    wire       hhStartRise;
    wire       hhStopRise;
    wire       ptStartRise;
    wire       ptStopHoldRise;
    wire       ptStopMomRise;
    wire       loopRise;

    // Contacts close to common, so invert to active high
    assign rawPins = {~safety_loop_b, ~portStop_n, ~portStart_n,
                      ~handheld_stop_in_n, ~handheld_start_in_n};

    // -----------------------------------------------------------------
    // Synchronisers
    // -----------------------------------------------------------------
    // sync every pin
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : gSync
            essi_sync uSync (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .asyncIn  (rawPins[gi]),
                .syncOut  (syncPins[gi])
            );
        end
    endgenerate

    // -----------------------------------------------------------------
    // Filters
    // -----------------------------------------------------------------
    // 1 ms start filter
    essi_filter #(.HOLD_CYC(MIN_CYC)) uPtStart (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .rawIn     (syncPins[2]),
        .stableOut (ptStartOk),
        .risePulse (ptStartRise)
    );

    essi_filter #(.HOLD_CYC(MIN_CYC)) uPtStopHold (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .rawIn     (syncPins[3]),
        .stableOut (ptStopHold),
        .risePulse (ptStopHoldRise)
    );

    essi_filter #(.HOLD_CYC(MOM_CYC)) uPtStopMom (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .rawIn     (syncPins[3]),
        .stableOut (ptStopMom),
        .risePulse (ptStopMomRise)
    );

    // handheld contacts use same 1 ms window
    essi_filter #(.HOLD_CYC(MIN_CYC)) uHhStart (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .rawIn     (syncPins[0]),
        .stableOut (hhStartOk),
        .risePulse (hhStartRise)
    );

    essi_filter #(.HOLD_CYC(MIN_CYC)) uHhStop (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .rawIn     (syncPins[1]),
        .stableOut (hhStopOk),
        .risePulse (hhStopRise)
    );

    // Loop filter keeps a bouncing key from opening the gate
    essi_filter #(.HOLD_CYC(MOM_CYC)) uLoop (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .rawIn     (syncPins[4]),
        .stableOut (loopClosed),
        .risePulse (loopRise)
    );

    // -----------------------------------------------------------------
    // Source gating
    // -----------------------------------------------------------------
    wire selPanel = isSrc(controlSource, `ESSI_SRC_PANEL);
    wire selHh    = isSrc(controlSource, `ESSI_SRC_HANDHELD);
    wire selPort  = isSrc(controlSource, `ESSI_SRC_SIGIO);

    reg panelStartQ;
    reg panelStopQ;
    wire panelStartRise = panelStart & ~panelStartQ;
    wire panelStopRise  = panelStop & ~panelStopQ;

    // port acts only when selected; handheld excludes others; panel
    wire startReq = (selPanel & panelStartRise)
                  | (selHh & hhStartRise)
                  | (selPort & ptStartRise);

    // handheld stop only when selected; panel stop always
    wire stopReq  = panelStopRise
                  | (selHh & hhStopRise)
                  | (selPort & ptStopMomRise);

    wire readyReq = (selPort & ptStopHoldRise) | stopReq;

    // loop must be closed; ignored when off
    wire lockOk = ~interlockEnable | loopClosed;

    // -----------------------------------------------------------------
    // Test state machine
    // -----------------------------------------------------------------
    localparam [`ESSI_ST_W-1:0] ST_IDLE  = `ESSI_ST_IDLE;
    localparam [`ESSI_ST_W-1:0] ST_READY = `ESSI_ST_READY;
    localparam [`ESSI_ST_W-1:0] ST_RUN   = `ESSI_ST_RUN;

    reg [`ESSI_ST_W-1:0] state;
    reg [`ESSI_ST_W-1:0] next_state;
    reg                  passFlag;
    reg                  failFlag;

    // Next state; stop has priority over start in the same cycle
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (readyReq) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (!stopReq && startReq && lockOk) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stopReq || testDone) begin
                    next_state = ST_READY;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State, panel edge capture and engine strobes
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= ST_IDLE;
            panelStartQ <= 1'b0;
            panelStopQ  <= 1'b0;
            testStart   <= 1'b0;
            testAbort   <= 1'b0;
            passFlag    <= 1'b0;
            failFlag    <= 1'b0;
        end else begin
            state       <= next_state;
            panelStartQ <= panelStart;
            panelStopQ  <= panelStop;
            testStart   <= (state == ST_READY) && (next_state == ST_RUN);
            testAbort   <= (state == ST_RUN) && stopReq;
            if ((state == ST_READY) && (next_state == ST_RUN)) begin
                passFlag <= 1'b0;
                failFlag <= 1'b0;
            end else if ((state == ST_RUN) && testDone && !stopReq) begin
                passFlag <= testPass;
                failFlag <= ~testPass;
            end
        end
    end

    // -----------------------------------------------------------------
    // Status lines and loop drive
    // -----------------------------------------------------------------
    // registered status outputs
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            statusOut     <= {`ESSI_STAT_W{1'b0}};
            safety_loop_a <= 1'b0;
        end else begin
            statusOut[`ESSI_STAT_READY]  <= (state == ST_READY);
            statusOut[`ESSI_STAT_RUN]    <= (state == ST_RUN);
            statusOut[`ESSI_STAT_PASS]   <= passFlag;
            statusOut[`ESSI_STAT_FAIL]   <= failFlag;
            statusOut[`ESSI_STAT_LOCKOK] <= lockOk;
            safety_loop_a <= 1'b0;  // Loop A held at common
        end
    end

endmodule

`default_nettype wire

// >>> sim/essi_top_monitor.sv
// Concurrent checks on the start/stop interlock block ports
`timescale 1ns/1ps
`default_nettype none
`include "essi_defines.vh"
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module essi_top_monitor (
    // Clock and reset
    input wire logic                    core_clk,
    input wire logic                    reset_n,
    // Settings and contacts
    input wire logic [`ESSI_SRC_W-1:0]  controlSource,
    input wire logic                    interlockEnable,
    input wire logic                    panelStart,
    input wire logic                    panelStop,
    input wire logic                    handheld_start_in_n,
    input wire logic                    handheld_stop_in_n,
    input wire logic                    portStart_n,
    input wire logic                    portStop_n,
    input wire logic                    safety_loop_b,
    input wire logic                    testDone,
    input wire logic                    testPass,
    // Block outputs
    input wire logic                    safety_loop_a,
    input wire logic                    testStart,
    input wire logic                    testAbort,
    input wire logic [`ESSI_STAT_W-1:0] statusOut
);
    // One clock domain, so one default for all
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_START_ONE: assert property (testStart |=> !testStart)
        else $error("start pulse longer than one cycle");
    AST_START_RUN: assert property (testStart |=> statusOut[`ESSI_STAT_RUN])
        else $error("run status missing at start");
    AST_LOOP_DRIVE: assert property (!safety_loop_a)
        else $error("loop drive not low");
    AST_LOCK_GATE: assert property ((interlockEnable && safety_loop_b) [*8]
        |=> !(testStart && interlockEnable && safety_loop_b))
        else $error("start with open safety loop");
    AST_LOCK_OFF: assert property (!interlockEnable [*3] |-> statusOut[`ESSI_STAT_LOCKOK])
        else $error("start not permitted with interlock off");
    AST_SRC_NONE: assert property ((controlSource == 2'h3) [*8] |=> !testStart)
        else $error("start with no source selected");
    AST_PANEL_STOP: assert property ($rose(panelStop) && statusOut[`ESSI_STAT_RUN] && !testDone
        |-> ##[1:3] testAbort)
        else $error("panel stop did not abort");
    AST_PANEL_START: assert property ($rose(panelStart) && !panelStop
        && statusOut[`ESSI_STAT_READY] && statusOut[`ESSI_STAT_LOCKOK]
        && controlSource == `ESSI_SRC_PANEL |-> ##[1:3] testStart)
        else $error("panel start ignored");
    AST_ABORT_RUN: assert property (testAbort |-> statusOut[`ESSI_STAT_RUN])
        else $error("abort outside a run");

    // Main scenarios reached
    COV_START: cover property (testStart);
    COV_ABORT: cover property (testAbort);
    COV_LOCKED: cover property (interlockEnable && !safety_loop_b && testStart);
endmodule

bind essi_top essi_top_monitor u_mon (
    .core_clk(core_clk), .reset_n(reset_n), .controlSource(controlSource),
    .interlockEnable(interlockEnable), .panelStart(panelStart), .panelStop(panelStop),
    .handheld_start_in_n(handheld_start_in_n), .handheld_stop_in_n(handheld_stop_in_n),
    .portStart_n(portStart_n), .portStop_n(portStop_n), .safety_loop_b(safety_loop_b),
    .testDone(testDone), .testPass(testPass), .safety_loop_a(safety_loop_a),
    .testStart(testStart), .testAbort(testAbort), .statusOut(statusOut));
`default_nettype wire

// >>> sim/essi_contact_model.sv
// Contact closure model for the handheld and signal-port lines
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Contact model
// ----------------------------------------------------------------
module essi_contact_model (
    // Clock
    input  wire logic core_clk,
    // Loop drive from the block
    input  wire logic safety_loop_a,
    // Contact lines, pulled up while open
    output wire logic handheld_start_in_n,
    output wire logic handheld_stop_in_n,
    output wire logic portStart_n,
    output wire logic portStop_n,
    output wire logic safety_loop_b
);
    // Closed: 0 handheld start, 1 handheld stop, 2 port start, 3 port stop
    logic [3:0] closed;
    logic       keyIn;

    initial begin
        closed = 4'h0;
        keyIn  = 1'b0;
    end

    // Open lines rest at the pull-up level
    assign handheld_start_in_n = ~closed[0];
    assign handheld_stop_in_n  = ~closed[1];
    assign portStart_n         = ~closed[2];
    assign portStop_n          = ~closed[3];
    // Key shorts loop B onto the driven loop A; open loop floats high
    assign safety_loop_b       = keyIn ? safety_loop_a : 1'b1;

    // Change one contact just after an edge
    task automatic contact(input int idx, input logic val);
        @(posedge core_clk);
        closed[idx] <= val;
    endtask

    // Insert or pull the interlock key
    task automatic set_key(input logic val);
        @(posedge core_clk);
        keyIn <= val;
    endtask

    task automatic press(input int idx, input int cycles);
        contact(idx, 1'b1);
        repeat (cycles) @(posedge core_clk);
        closed[idx] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> sim/test_essi_top.sv
// Self-checking bench for the start/stop interlock block
`timescale 1ns/1ps
`default_nettype none
`include "essi_defines.vh"
// Look 1 ns past the edge, once registered outputs have settled
`define CHK(got, exp) begin #1; check_val(5'(got), 5'(exp)); end
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module test_essi_top;
    // Stimulus and observed signals
    logic                    core_clk, reset_n, interlockEnable, panelStart, panelStop;
    logic                    testDone, testPass, safety_loop_a, testStart, testAbort;
    logic [`ESSI_SRC_W-1:0]  controlSource;
    logic [`ESSI_STAT_W-1:0] statusOut;
    wire                     hStartN, hStopN, pStartN, pStopN, loopB;
    int                      miscompares, n_compared, startCnt, abortCnt, s, a;

    essi_top u_dut (.core_clk(core_clk), .reset_n(reset_n), .controlSource(controlSource),
        .interlockEnable(interlockEnable), .panelStart(panelStart), .panelStop(panelStop),
        .handheld_start_in_n(hStartN), .handheld_stop_in_n(hStopN), .portStart_n(pStartN),
        .portStop_n(pStopN), .safety_loop_b(loopB), .safety_loop_a(safety_loop_a),
        .testDone(testDone), .testPass(testPass), .testStart(testStart),
        .testAbort(testAbort), .statusOut(statusOut));
    essi_contact_model u_far (.core_clk(core_clk), .safety_loop_a(safety_loop_a),
        .handheld_start_in_n(hStartN), .handheld_stop_in_n(hStopN), .portStart_n(pStartN),
        .portStop_n(pStopN), .safety_loop_b(loopB));

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Pulse counters, so checks never race the one-cycle pulses
    always @(posedge core_clk) begin
        if (testStart === 1'b1) startCnt++;
        if (testAbort === 1'b1) abortCnt++;
    end
    // Watchdog sized a little above the two 1 ms closures
    initial begin
        #2400000;
        miscompares++;
        report_and_stop;
    end

    task check_val(input logic [4:0] got, input logic [4:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("compared=%0d miscompares=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One-cycle panel button press, then settle
    task press_panel(input logic stop);
        @(posedge core_clk);
        if (stop) panelStop <= 1'b1;
        else panelStart <= 1'b1;
        @(posedge core_clk);
        panelStart <= 1'b0;
        panelStop  <= 1'b0;
        tick(4);
    endtask

    // Panel start refused in idle, stop readies, start runs, done latches pass
    task test_panel;
        s = startCnt;
        press_panel(1'b0);
        `CHK(startCnt, s);
        press_panel(1'b1);
        `CHK(statusOut, 5'h11);
        press_panel(1'b0);
        `CHK(startCnt, s + 1);
        @(posedge core_clk);
        testDone <= 1'b1;
        testPass <= 1'b1;
        @(posedge core_clk);
        testDone <= 1'b0;
        tick(3);
        `CHK(statusOut, 5'h15);
    endtask
    // Interlock on: open loop blocks, closed loop permits
    task test_lock;
        s = startCnt;
        a = abortCnt;
        @(posedge core_clk);
        interlockEnable <= 1'b1;
        tick(5);
        `CHK(statusOut[`ESSI_STAT_LOCKOK], 1'b0);
        press_panel(1'b0);
        `CHK(startCnt, s);
        u_far.set_key(1'b1);
        tick(5);
        press_panel(1'b0);
        `CHK(startCnt, s + 1);
        press_panel(1'b1);
        `CHK(abortCnt, a + 1);
        @(posedge core_clk);
        interlockEnable <= 1'b0;
        u_far.set_key(1'b0);
    endtask
    // Handheld source: port start closed first must not count
    task test_handheld;
        s = startCnt;
        a = abortCnt;
        @(posedge core_clk);
        controlSource <= 2'h3;
        tick(8);
        press_panel(1'b0);
        `CHK(startCnt, s);
        @(posedge core_clk);
        controlSource <= `ESSI_SRC_HANDHELD;
        press_panel(1'b0);
        `CHK(startCnt, s);
        u_far.contact(2, 1'b1);
        tick(200);
        u_far.contact(0, 1'b1);
        tick(49900);
        `CHK(startCnt, s);
        tick(300);
        `CHK(startCnt, s + 1);
        `CHK(statusOut[`ESSI_STAT_RUN], 1'b1);
        u_far.contact(0, 1'b0);
        u_far.contact(2, 1'b0);
        press_panel(1'b1);
        `CHK(abortCnt, a + 1);
    endtask
    // Signal port: short start refused, long stop readies, long start runs
    task test_port;
        s = startCnt;
        a = abortCnt;
        @(posedge core_clk);
        controlSource <= `ESSI_SRC_PANEL;
        press_panel(1'b0);
        `CHK(startCnt, s + 1);
        @(posedge core_clk);
        controlSource <= `ESSI_SRC_SIGIO;
        press_panel(1'b1);
        `CHK(abortCnt, a + 1);
        @(posedge core_clk);
        reset_n <= 1'b0;
        tick(4);
        reset_n <= 1'b1;
        tick(3);
        `CHK(statusOut, 5'h10);
        u_far.contact(3, 1'b1);
        tick(100);
        u_far.press(2, 1000);
        tick(10);
        `CHK(startCnt, s + 1);
        u_far.contact(2, 1'b1);
        tick(49950);
        u_far.contact(3, 1'b0);
        tick(2);
        `CHK(statusOut[`ESSI_STAT_READY], 1'b1);
        tick(250);
        u_far.contact(2, 1'b0);
        `CHK(startCnt, s + 2);
        u_far.press(3, 10);
        tick(5);
        `CHK(abortCnt, a + 2);
    endtask

    // Main sequence
    initial begin
        controlSource   = `ESSI_SRC_PANEL;
        interlockEnable = 1'b0;
        panelStart      = 1'b0;
        panelStop       = 1'b0;
        testDone        = 1'b0;
        testPass        = 1'b0;
        reset_n         = 1'b0;
        miscompares     = 0;
        n_compared      = 0;
        startCnt        = 0;
        abortCnt        = 0;
        tick(4);
        reset_n <= 1'b1;
        `CHK(statusOut, 5'h00);
        tick(3);
        `CHK(statusOut, 5'h10);
        `CHK(safety_loop_a, 1'b0);
        test_panel;
        test_lock;
        test_handheld;
        test_port;
        report_and_stop;
    end
endmodule
`default_nettype wire
